// ---- include/bsd_pkg.sv ----
// Package for the bank-select I/O decoder: offsets, groups, targets, bus carrier.
// Assumes the host bus is sampled synchronously on the system clock.
package bsd_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int BASE_W = 5;

  // Port offsets inside the eight-port window
  localparam logic [2:0] OFF_0 = 3'h0;
  localparam logic [2:0] OFF_1 = 3'h1;
  localparam logic [2:0] OFF_2 = 3'h2;
  localparam logic [2:0] OFF_3 = 3'h3;
  localparam logic [2:0] OFF_4 = 3'h4;
  localparam logic [2:0] OFF_5 = 3'h5;
  localparam logic [2:0] OFF_6 = 3'h6;
  localparam logic [2:0] OFF_BANK_CHOICE = 3'h7;

  // Field positions of the bank_choice write data
  localparam int BANK_LSB = 0;
  localparam int BANK_MSB = 1;

  // Value after reset of bank_choice: group zero, a safe default
  localparam logic [1:0] BANK_RESET = 2'h0;

  typedef enum logic [1:0] {
    BSD_GRP_MISC = 2'b00,
    BSD_GRP_SER1 = 2'b01,
    BSD_GRP_SER2 = 2'b10,
    BSD_GRP_SER3 = 2'b11
  } bsd_group_t;

  // Register targets in group zero
  typedef enum logic [3:0] {
    BSD_T_NONE     = 4'b0000,
    BSD_T_PRN_STAT = 4'b0001,
    BSD_T_FLAGS    = 4'b0010,
    BSD_T_CLK      = 4'b0011,
    BSD_T_PAR_DATA = 4'b0100,
    BSD_T_IRQ0     = 4'b0101,
    BSD_T_IRQ1     = 4'b0110,
    BSD_T_PRN_OUT0 = 4'b0111,
    BSD_T_PRN_OUT1 = 4'b1000,
    BSD_T_PAR_CTRL = 4'b1001
  } bsd_target_t;

  // Host I/O cycle as seen by the board
  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bsd_io_req_t;

  // Select strobes handed to the peripherals
  typedef struct packed {
    logic [3:0] misc_rd;
    logic [3:0] misc_wr;
    logic [2:0] ser_rd;
    logic [2:0] ser_wr;
    logic [2:0] reg_idx;
    logic clk_irq_clr;
  } bsd_sel_t;

endpackage : bsd_pkg

// ---- hw/bsd_decoder.sv ----
// Bank-select I/O port decoder: window match, group register, select strobes.
// Assumes host RD/WR strobes are one-cycle pulses synchronous to CLK_I.
`timescale 1ns/1ns
module bsd_decoder #(
  parameter int BASE_W = bsd_pkg::BASE_W
) (
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic [BASE_W-1:0] ADDRESS_SWITCH_BANK_ON_I,
  input wire bsd_pkg::bsd_io_req_t IO_REQ_I,
  output bsd_pkg::bsd_sel_t SEL_O,
  output logic [1:0] BANK_O,
  output logic HIT_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Window match

  logic [1:0] bank_choice_r;
  logic [1:0] bank_choice_nxt;
  bsd_pkg::bsd_sel_t sel_r;
  bsd_pkg::bsd_sel_t sel_nxt;
  logic hit_r;

  wire [BASE_W-1:0] base_bits = ~ADDRESS_SWITCH_BANK_ON_I;
  wire [BASE_W-1:0] addr_hi = IO_REQ_I.addr[bsd_pkg::ADDR_W-1 -: BASE_W];
  wire window_hit = (addr_hi == base_bits);
  wire [2:0] offset = IO_REQ_I.addr[2:0];
  wire cyc_rd = window_hit & IO_REQ_I.rd;
  wire cyc_wr = window_hit & IO_REQ_I.wr;
  wire is_choice = (offset == bsd_pkg::OFF_BANK_CHOICE);
  wire choice_wr = cyc_wr & is_choice;
  wire body_rd = cyc_rd & ~is_choice;
  wire body_wr = cyc_wr & ~is_choice;
  wire in_misc = (bank_choice_r == bsd_pkg::BSD_GRP_MISC);

  ////////////////////////////////////////////////////////////////////////////
  // Target mapping

  // Group zero read target for an offset; offset six reads nothing
  function automatic bsd_pkg::bsd_target_t misc_rd_target(input logic [2:0] off);
    bsd_pkg::bsd_target_t t;
    t = bsd_pkg::BSD_T_NONE;
    if (off == bsd_pkg::OFF_0) begin
      t = bsd_pkg::BSD_T_PRN_STAT;
    end else if (off == bsd_pkg::OFF_1) begin
      t = bsd_pkg::BSD_T_FLAGS;
    end else if (off == bsd_pkg::OFF_2) begin
      t = bsd_pkg::BSD_T_CLK;
    end else if (off == bsd_pkg::OFF_3) begin
      t = bsd_pkg::BSD_T_PAR_DATA;
    end else if (off == bsd_pkg::OFF_4) begin
      t = bsd_pkg::BSD_T_IRQ0;
    end else if (off == bsd_pkg::OFF_5) begin
      t = bsd_pkg::BSD_T_IRQ1;
    end
    return t;
  endfunction : misc_rd_target

  function automatic bsd_pkg::bsd_target_t misc_wr_target(input logic [2:0] off);
    bsd_pkg::bsd_target_t t;
    t = bsd_pkg::BSD_T_NONE;
    if (off == bsd_pkg::OFF_0) begin
      t = bsd_pkg::BSD_T_PRN_OUT0;
    end else if (off == bsd_pkg::OFF_1) begin
      t = bsd_pkg::BSD_T_PRN_OUT1;
    end else if (off == bsd_pkg::OFF_2) begin
      t = bsd_pkg::BSD_T_CLK;
    end else if (off == bsd_pkg::OFF_3) begin
      t = bsd_pkg::BSD_T_PAR_DATA;
    end else if (off == bsd_pkg::OFF_4) begin
      t = bsd_pkg::BSD_T_IRQ0;
    end else if (off == bsd_pkg::OFF_5) begin
      t = bsd_pkg::BSD_T_IRQ1;
    end else if (off == bsd_pkg::OFF_6) begin
      t = bsd_pkg::BSD_T_PAR_CTRL;
    end
    return t;
  endfunction : misc_wr_target

  // Target code, forced to zero when no cycle is taken
  function automatic logic [3:0] tgt_strobe(input bsd_pkg::bsd_target_t t, input logic en);
    logic [3:0] s;
    s = 4'h0;
    if (en && t != bsd_pkg::BSD_T_NONE) begin
      s = t;
    end
    return s;
  endfunction : tgt_strobe

  wire bsd_pkg::bsd_target_t rd_tgt = misc_rd_target(offset);
  wire bsd_pkg::bsd_target_t wr_tgt = misc_wr_target(offset);
  wire [3:0] misc_rd_code = tgt_strobe(rd_tgt, body_rd & in_misc);
  wire [3:0] misc_wr_code = tgt_strobe(wr_tgt, body_wr & in_misc);

  // Serial element writes land only at offsets 0, 1, 3 and 4
  wire ser_wr_ok = (offset == bsd_pkg::OFF_0) | (offset == bsd_pkg::OFF_1) |
                   (offset == bsd_pkg::OFF_3) | (offset == bsd_pkg::OFF_4);
  wire [2:0] ser_onehot = (bank_choice_r == bsd_pkg::BSD_GRP_SER1) ? 3'h1 :
                          (bank_choice_r == bsd_pkg::BSD_GRP_SER2) ? 3'h2 :
                          (bank_choice_r == bsd_pkg::BSD_GRP_SER3) ? 3'h4 : 3'h0;
  wire [2:0] ser_rd = body_rd ? ser_onehot : 3'h0;
  wire [2:0] ser_wr = (body_wr & ser_wr_ok) ? ser_onehot : 3'h0;
  wire clk_clr = body_rd & in_misc & (offset == bsd_pkg::OFF_2);

  // Group register holds until the next offset-seven write
  assign bank_choice_nxt = choice_wr ?
    IO_REQ_I.wdata[bsd_pkg::BANK_MSB:bsd_pkg::BANK_LSB] : bank_choice_r;

  always_comb begin
    sel_nxt = '0;
    sel_nxt.misc_rd = misc_rd_code;
    sel_nxt.misc_wr = misc_wr_code;
    sel_nxt.ser_rd = ser_rd;
    sel_nxt.ser_wr = ser_wr;
    sel_nxt.reg_idx = offset;
    sel_nxt.clk_irq_clr = clk_clr;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      bank_choice_r <= bsd_pkg::BANK_RESET;
      sel_r <= '0;
      hit_r <= 1'b0;
    end else begin
      bank_choice_r <= bank_choice_nxt;
      sel_r <= sel_nxt;
      hit_r <= cyc_rd | cyc_wr;
    end
  end

  assign SEL_O = sel_r;
  assign BANK_O = bank_choice_r;
  assign HIT_O = hit_r;

endmodule : bsd_decoder

// ---- testbench/bsd_host.sv ----
// Host model: issues one-cycle I/O read and write pulses.
// Assumes the decoder samples requests on the rising clock edge.
`timescale 1ns/1ns
module bsd_host (
  input wire logic clk_i,
  output bsd_pkg::bsd_io_req_t req_o
);
  initial req_o = '0;
  task automatic io(input logic wr, input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk_i);
    req_o <= {!wr, wr, addr, data};
    @(posedge clk_i);
    // Released lines show the inverse, never a stale value
    req_o <= {2'b00, ~addr, ~data};
  endtask : io
  // Upper data bits set so that only bits 1:0 may count
  task automatic pick(input logic [7:0] base, input logic [1:0] g);
    io(1'b1, base | 8'h07, {6'h2a, g});
  endtask : pick
endmodule : bsd_host

// ---- testbench/bsd_decoder_chk.sv ----
// Checker on the decoder ports, bound into the decoder.
// Assumes rd and wr are one-cycle pulses on CLK_I.
`timescale 1ns/1ns
module bsd_decoder_chk #(
  parameter int BASE_W = bsd_pkg::BASE_W
) (
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic [BASE_W-1:0] ADDRESS_SWITCH_BANK_ON_I,
  input wire bsd_pkg::bsd_io_req_t IO_REQ_I,
  input wire bsd_pkg::bsd_sel_t SEL_O,
  input wire logic [1:0] BANK_O,
  input wire logic HIT_O
);
  wire hit_w = (IO_REQ_I.rd | IO_REQ_I.wr) && IO_REQ_I.addr[7:3] == ~ADDRESS_SWITCH_BANK_ON_I;
  wire rd_w = hit_w && IO_REQ_I.rd;
  wire wr_w = hit_w && IO_REQ_I.wr;
  wire [2:0] off = IO_REQ_I.addr[2:0];
  wire bank_wr_w = wr_w && off == 3'h7;
  // reg_idx follows the address on every cycle, so only strobes must stay quiet
  wire [14:0] strobes = {SEL_O.misc_rd, SEL_O.misc_wr, SEL_O.ser_rd, SEL_O.ser_wr,
    SEL_O.clk_irq_clr};
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);
  sequence ser_rd_s;
    rd_w && off != 3'h7 && BANK_O != 2'h0;
  endsequence
  window_hit_a: assert property (hit_w |=> HIT_O) else $error("hit missing");
  miss_quiet_a: assert property (!hit_w |=> !HIT_O && strobes == 15'h0)
    else $error("strobe without hit");
  bank_load_a: assert property (bank_wr_w |=> BANK_O == $past(IO_REQ_I.wdata[1:0]))
    else $error("bank not loaded");
  bank_hold_a: assert property (!bank_wr_w |=> $stable(BANK_O)) else $error("bank moved");
  ser_sel_a: assert property (ser_rd_s
    |=> SEL_O.ser_rd == 3'h1 << ($past(BANK_O) - 2'h1) && SEL_O.reg_idx == $past(off))
    else $error("serial select wrong");
  clk_clr_a: assert property (rd_w && off == 3'h2 && BANK_O == 2'h0
    |=> SEL_O.clk_irq_clr && SEL_O.misc_rd == 4'h3) else $error("clock clear missing");
  par_ctrl_a: assert property (wr_w && off == 3'h6 && BANK_O == 2'h0
    |=> SEL_O.misc_wr == 4'h9) else $error("control write wrong");
  ser_nowr_a: assert property (wr_w && BANK_O != 2'h0 && off inside {3'h2, 3'h5, 3'h6}
    |=> SEL_O.ser_wr == 3'h0) else $error("unused serial write");
  top_read_a: assert property (rd_w && !IO_REQ_I.wr && off == 3'h7
    |=> strobes == 15'h0 && HIT_O) else $error("top port read strobed");
endmodule : bsd_decoder_chk
bind bsd_decoder bsd_decoder_chk #(.BASE_W(BASE_W)) bsd_decoder_chk_inst (.CLK_I(CLK_I),
  .NRST_I(NRST_I), .ADDRESS_SWITCH_BANK_ON_I(ADDRESS_SWITCH_BANK_ON_I),
  .IO_REQ_I(IO_REQ_I), .SEL_O(SEL_O), .BANK_O(BANK_O), .HIT_O(HIT_O));

// ---- testbench/bsd_decoder_test.sv ----
// Testbench for the bank-select decoder.
// Assumes the host model and bound checker are compiled first.
`timescale 1ns/1ns
module bsd_decoder_test;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [4:0] sw_on = 5'h16;
  bsd_pkg::bsd_io_req_t req;
  bsd_pkg::bsd_sel_t sel;
  logic [1:0] bank;
  logic hit;
  wire [14:0] strobes = {sel.misc_rd, sel.misc_wr, sel.ser_rd, sel.ser_wr, sel.clk_irq_clr};
  logic [15:0] r;
  logic [14:0] ex;
  int num_errors = 0;
  int check_count = 0;
  // Nibbles: bank, {wr, offset}, group-zero code, serial one-hot
  logic [15:0] rows [25] = '{16'h0010, 16'h0120, 16'h0230, 16'h0340, 16'h0450, 16'h0560,
    16'h0600, 16'h0870, 16'h0980, 16'h0a30, 16'h0b40, 16'h0c50, 16'h0d60, 16'h0e90,
    16'h1001, 16'h2502, 16'h3604, 16'h3804, 16'h2a00, 16'h1d00, 16'h1e00, 16'h2902,
    16'h1b01, 16'h3c04, 16'h2302};
  always #4 clk_i = ~clk_i;
  bsd_host bsd_host_inst (.clk_i(clk_i), .req_o(req));
  bsd_decoder bsd_decoder_inst (.CLK_I(clk_i), .NRST_I(nrst_i),
    .ADDRESS_SWITCH_BANK_ON_I(sw_on), .IO_REQ_I(req), .SEL_O(sel), .BANK_O(bank), .HIT_O(hit));
  task automatic chk(input string n, input logic [17:0] s, e);
    check_count++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  initial begin
    repeat (3) @(posedge clk_i);
    chk("reset", {bank, hit, strobes}, 18'h0);
    nrst_i <= 1'b1;
    foreach (rows[i]) begin
      r = rows[i];
      bsd_host_inst.pick(8'h48, r[13:12]);
      bsd_host_inst.io(r[11], 8'h48 | r[10:8], 8'h5a);
      ex = r[11] ? {4'h0, r[7:4], 3'h0, r[2:0], 1'b0}
        : {r[7:4], 4'h0, r[2:0], 3'h0, r[15:8] == 8'h02};
      #1;
      chk("hit", hit, 1'b1);
      chk("sel", strobes, ex);
      chk("idx", sel.reg_idx, r[10:8]);
    end
    $display("table done");
    ////////////////////////////////////////////////////////////////////////
    bsd_host_inst.io(1'b0, 8'h4f, 8'h01);
    #1;
    chk("top read", {bank, hit, strobes}, {2'h2, 1'b1, 15'h0});
    bsd_host_inst.io(1'b1, 8'h57, 8'h01);
    #1;
    chk("miss", {bank, hit}, {2'h2, 1'b0});
    @(posedge clk_i) sw_on <= 5'h1f;
    bsd_host_inst.io(1'b1, 8'h4f, 8'h01);
    #1;
    chk("old base", {bank, hit}, {2'h2, 1'b0});
    bsd_host_inst.pick(8'h00, 2'h3);
    #1;
    chk("base zero", {bank, hit}, {2'h3, 1'b1});
    // Second reset in mid-run must drop the chosen group
    @(posedge clk_i) nrst_i <= 1'b0;
    @(posedge clk_i) nrst_i <= 1'b1;
    #1;
    chk("mid reset", {bank, hit, strobes}, 18'h0);
    $display("hand tests done");
    end_sim;
  end
  initial begin
    repeat (400) @(posedge clk_i);
    num_errors++;
    end_sim;
  end
endmodule : bsd_decoder_test
